// ### hw/tcc_timers.sv
// three 16-bit timer/counters with baud ticks and programmable clock-out, apb slave
//
// Overview of operation
// - timer0 mode nibble: 13/16-bit, 8-bit reload, split; +4 counts events, +8 pin gate
// - internal control: timer0 runs while its run bit is set
// - external control: timer0 toggled on/off by irq0 pin falls while run bit set
// - timer1 uses upper nibble, same modes; mode 3 holds count still
// - internal control: timer1 runs according to its own run bit
// - external control: timer1 toggled on/off by irq1 pin falls while run bit set
// - timer2 control: reload 00h, capture 01h, +02h counts events, +08h trigger pin
// - timer2 baud generator for both, receive only or transmit only directions
// - internal control: timer2 reloads on overflow, or in capture mode wraps to 0000h
// - external control: also capture or reload on trigger pin fall
// - in baud mode trigger pin fall causes no capture or reload
// - timer2 drives a 50% duty clock on port pin p10
// - same pin is timer2 external count input otherwise
// - clock-out frequency is fosc over n times (65536 minus reload), n 2 or 4
// - timer2 overflows raise no flag while clock-out is active
// - baud generation and clock-out may run together
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
module tcc_timers
    import tcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq0_pin,
    input wire logic ext_irq1_pin,
    input wire logic t0_count_pin,
    input wire logic t1_count_pin,
    input wire logic timer2_trigger_pin,
    input wire logic p10_pin_i,
    output logic p10_pin_o,
    output logic p10_pin_oe,
    output logic t0_ovf_flag,
    output logic t1_ovf_flag,
    output logic t2_ovf_flag,
    output logic t2_ext_flag,
    output logic baud_rx_tick,
    output logic baud_tx_tick
);

    // ----------------------------------------------------------------
    // pin synchronisers and tick generator
    // ----------------------------------------------------------------
    tcc_pins_s pins_raw;
    tcc_pins_s pins_fall;
    logic mc_tick;
    logic fast_tick;
    tcc_state_s s_r;
    tcc_state_s s_nxt;

    always_comb
    begin
        pins_raw.irq0 = ext_irq0_pin;
        pins_raw.irq1 = ext_irq1_pin;
        pins_raw.t0_cnt = t0_count_pin;
        pins_raw.t1_cnt = t1_count_pin;
        pins_raw.trig = timer2_trigger_pin;
        // while driving p10 the pin reads back our own clock; it is ignored then
        pins_raw.p10 = p10_pin_i;
    end

    tcc_pin_sync u_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .pins(pins_raw),
        .level(),
        .fall(pins_fall)
    );

    tcc_prescaler u_presc
    (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .six_clk(s_r.six_clk),
        .mc_tick(mc_tick),
        .fast_tick(fast_tick)
    );

    // ----------------------------------------------------------------
    // decoded control
    // ----------------------------------------------------------------
    tcc_mode_e t0_mode;
    tcc_mode_e t1_mode;
    logic t0_run;
    logic t1_run;
    logic t0_step;
    logic t1_step;
    logic t2_counter_sel;
    logic t2_baud;
    logic t2_clkout_mode;
    logic t2_fast;
    logic t2_capture;
    logic t2_step;
    logic t2_trig;
    logic acc;
    logic wr;
    logic rd_hit;
    logic [31:0] rd_val;
    tcc_step_s st0;
    tcc_step_s st1;
    logic t0_ovf_set;
    logic t1_ovf_set;
    logic t2_ovf_set;
    logic t2_ext_set;

    always_comb
    begin
        t0_mode = tcc_mode_e'(s_r.t01_mode[NIB_MODE_LSB +: 2]);
        t1_mode = tcc_mode_e'(s_r.t01_mode[T1_NIB_LSB + NIB_MODE_LSB +: 2]);
        // run: software bit alone, or software bit and pin-toggled gate
        t0_run = s_r.t01_ctrl[T0_RUN_BIT]
            & (~s_r.t01_mode[NIB_GATE] | s_r.t0_gate_on);
        t1_run = s_r.t01_ctrl[T1_RUN_BIT]
            & (~s_r.t01_mode[T1_NIB_LSB + NIB_GATE] | s_r.t1_gate_on);
        // count source: machine cycle, or falling edge on the count pin
        t0_step = s_r.t01_mode[NIB_COUNTER] ? pins_fall.t0_cnt : mc_tick;
        t1_step = s_r.t01_mode[T1_NIB_LSB + NIB_COUNTER] ? pins_fall.t1_cnt : mc_tick;
        t2_counter_sel = s_r.t2_ctrl[T2_COUNTER_SEL_BIT];
        t2_baud = s_r.t2_ctrl[T2_RX_BAUD_BIT] | s_r.t2_ctrl[T2_TX_BAUD_BIT];
        t2_clkout_mode = s_r.t2_mode[T2_CLKOUT_EN_BIT] & ~t2_counter_sel;
        // baud and clock-out modes count at n/2 oscillator clocks per step
        t2_fast = t2_baud | t2_clkout_mode;
        t2_capture = s_r.t2_ctrl[T2_CAPTURE_BIT] & ~t2_fast;
        t2_step = s_r.t2_ctrl[T2_RUN_BIT]
            & (t2_counter_sel ? pins_fall.p10 : (t2_fast ? fast_tick : mc_tick));
        t2_trig = s_r.t2_ctrl[T2_TRIG_EN_BIT] & pins_fall.trig;
        st0 = tcc_step(t0_mode, s_r.t0_cnt);
        st1 = tcc_step(t1_mode, s_r.t1_cnt);
        acc = ce & psel & penable & ~s_r.pready;
        wr = ce & psel & penable & s_r.pready & pwrite;
    end

    // ----------------------------------------------------------------
    // apb read mux
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_hit = 1'b1;
        rd_val = '0;
        unique case (paddr)
            OFS_T01_MODE: rd_val[7:0] = s_r.t01_mode;
            OFS_T01_CTRL: rd_val[7:0] = s_r.t01_ctrl;
            OFS_T2_CTRL: rd_val[7:0] = s_r.t2_ctrl;
            OFS_T2_MODE: rd_val[7:0] = s_r.t2_mode;
            OFS_T0_CNT: rd_val[15:0] = s_r.t0_cnt;
            OFS_T1_CNT: rd_val[15:0] = s_r.t1_cnt;
            OFS_T2_CNT: rd_val[15:0] = s_r.t2_cnt;
            OFS_T2_RELOAD: rd_val[15:0] = s_r.t2_reload;
            OFS_CLK_CFG: rd_val[SIX_CLK_BIT] = s_r.six_clk;
            default: rd_hit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        t0_ovf_set = 1'b0;
        t1_ovf_set = 1'b0;
        t2_ovf_set = 1'b0;
        t2_ext_set = 1'b0;
        if (ce)
        begin
            s_nxt.rx_tick = 1'b0;
            s_nxt.tx_tick = 1'b0;

            // apb: access phase takes two cycles; pready rises in the second
            s_nxt.pready = acc;
            // error stands only with its ready pulse, so the pin needs no gate
            s_nxt.pslverr = acc & ~rd_hit;
            if (acc)
            begin
                s_nxt.prdata = (!pwrite && rd_hit) ? rd_val : '0;
            end

            // pin gate: each falling edge toggles run while the run bit is set
            if (!s_r.t01_ctrl[T0_RUN_BIT])
                s_nxt.t0_gate_on = 1'b0;
            else if (pins_fall.irq0)
                s_nxt.t0_gate_on = ~s_r.t0_gate_on;
            if (!s_r.t01_ctrl[T1_RUN_BIT])
                s_nxt.t1_gate_on = 1'b0;
            else if (pins_fall.irq1)
                s_nxt.t1_gate_on = ~s_r.t1_gate_on;

            // timer0; in split mode its high byte borrows timer1's run bit and flag
            if (t0_mode == MODE_SPLIT)
            begin
                if (t0_run && t0_step)
                begin
                    s_nxt.t0_cnt[7:0] = s_r.t0_cnt[7:0] + 8'h01;
                    t0_ovf_set = (s_r.t0_cnt[7:0] == BYTE_MAX);
                end
                if (s_r.t01_ctrl[T1_RUN_BIT] && mc_tick)
                begin
                    s_nxt.t0_cnt[15:8] = s_r.t0_cnt[15:8] + 8'h01;
                    t1_ovf_set = (s_r.t0_cnt[15:8] == BYTE_MAX);
                end
            end
            else if (t0_run && t0_step)
            begin
                s_nxt.t0_cnt = st0.cnt;
                t0_ovf_set = st0.ovf;
            end

            // timer1 holds in mode 3 and has no flag while timer0 is split
            if (t1_mode != MODE_SPLIT && t1_run && t1_step)
            begin
                s_nxt.t1_cnt = st1.cnt;
                t1_ovf_set = t1_ovf_set | (st1.ovf & (t0_mode != MODE_SPLIT));
            end

            // timer2 counting, overflow reload or wrap
            if (t2_step)
            begin
                if (s_r.t2_cnt == CNT_MAX)
                begin
                    s_nxt.t2_cnt = t2_capture ? RST_WORD : s_r.t2_reload;
                    t2_ovf_set = ~t2_fast;
                    s_nxt.rx_tick = s_r.t2_ctrl[T2_RX_BAUD_BIT];
                    s_nxt.tx_tick = s_r.t2_ctrl[T2_TX_BAUD_BIT];
                    if (t2_clkout_mode)
                        s_nxt.clkout = ~s_r.clkout;
                end
                else
                    s_nxt.t2_cnt = s_r.t2_cnt + 16'h0001;
            end

            // timer2 trigger pin: flag always, capture or reload outside baud mode
            if (t2_trig)
            begin
                t2_ext_set = 1'b1;
                if (!t2_baud)
                begin
                    if (t2_capture)
                        s_nxt.t2_reload = s_r.t2_cnt;
                    else
                        s_nxt.t2_cnt = s_r.t2_reload;
                end
            end

            // pin drive follows clock-out mode; idle level low when released
            s_nxt.clkout_oe = t2_clkout_mode;
            if (!t2_clkout_mode)
                s_nxt.clkout = 1'b0;

            // apb writes take effect at the edge where pready is sampled high
            if (wr)
            begin
                unique case (paddr)
                    OFS_T01_MODE: s_nxt.t01_mode = pwdata[7:0];
                    OFS_T01_CTRL: s_nxt.t01_ctrl = pwdata[7:0];
                    OFS_T2_CTRL: s_nxt.t2_ctrl = pwdata[7:0];
                    OFS_T2_MODE: s_nxt.t2_mode = pwdata[7:0];
                    OFS_T0_CNT: s_nxt.t0_cnt = pwdata[15:0];
                    OFS_T1_CNT: s_nxt.t1_cnt = pwdata[15:0];
                    OFS_T2_CNT: s_nxt.t2_cnt = pwdata[15:0];
                    OFS_T2_RELOAD: s_nxt.t2_reload = pwdata[15:0];
                    OFS_CLK_CFG: s_nxt.six_clk = pwdata[SIX_CLK_BIT];
                    default: s_nxt.t01_mode = s_r.t01_mode;
                endcase
            end

            // hardware set wins over a software clear in the same cycle
            s_nxt.t01_ctrl[T0_OVF_BIT] = s_nxt.t01_ctrl[T0_OVF_BIT] | t0_ovf_set;
            s_nxt.t01_ctrl[T1_OVF_BIT] = s_nxt.t01_ctrl[T1_OVF_BIT] | t1_ovf_set;
            s_nxt.t2_ctrl[T2_OVF_BIT] = s_nxt.t2_ctrl[T2_OVF_BIT] | t2_ovf_set;
            s_nxt.t2_ctrl[T2_EXT_FLAG_BIT] = s_nxt.t2_ctrl[T2_EXT_FLAG_BIT] | t2_ext_set;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // outputs straight from the state register
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign p10_pin_o = s_r.clkout;
    assign p10_pin_oe = s_r.clkout_oe;
    assign t0_ovf_flag = s_r.t01_ctrl[T0_OVF_BIT];
    assign t1_ovf_flag = s_r.t01_ctrl[T1_OVF_BIT];
    assign t2_ovf_flag = s_r.t2_ctrl[T2_OVF_BIT];
    assign t2_ext_flag = s_r.t2_ctrl[T2_EXT_FLAG_BIT];
    assign baud_rx_tick = s_r.rx_tick;
    assign baud_tx_tick = s_r.tx_tick;

endmodule
`default_nettype wire

// ### hw/tcc_pkg.sv
// package of constants, types and helpers for the timer/counter block with clock-out
package tcc_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses on the apb bus)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_T01_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_T01_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_T2_CTRL = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_T2_MODE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_T0_CNT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_T1_CNT = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_T2_CNT = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_T2_RELOAD = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_CLK_CFG = 8'h20;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    // mode nibble: [1:0] mode, [2] count external events, [3] pin-gated run
    localparam int NIB_MODE_LSB = 0;
    localparam int NIB_COUNTER = 2;
    localparam int NIB_GATE = 3;
    localparam int T1_NIB_LSB = 4;
    // timer01_control_reg
    localparam int T0_RUN_BIT = 4;
    localparam int T0_OVF_BIT = 5;
    localparam int T1_RUN_BIT = 6;
    localparam int T1_OVF_BIT = 7;
    // timer2_control_reg
    localparam int T2_CAPTURE_BIT = 0;
    localparam int T2_COUNTER_SEL_BIT = 1;
    localparam int T2_RUN_BIT = 2;
    localparam int T2_TRIG_EN_BIT = 3;
    localparam int T2_TX_BAUD_BIT = 4;
    localparam int T2_RX_BAUD_BIT = 5;
    localparam int T2_EXT_FLAG_BIT = 6;
    localparam int T2_OVF_BIT = 7;
    // timer2_mode_reg
    localparam int T2_CLKOUT_EN_BIT = 1;
    // clock configuration: 1 selects 6 clocks per machine cycle
    localparam int SIX_CLK_BIT = 0;

    // ----------------------------------------------------------------
    // timing: oscillator clocks per count step
    // ----------------------------------------------------------------
    localparam int MC_CLKS_12 = 12;
    localparam int MC_CLKS_6 = 6;
    localparam int CLKOUT_N_12 = 4;
    localparam int CLKOUT_N_6 = 2;
    // the clock-out pin toggles once per overflow, so one count step is n/2 clocks
    localparam int FAST_CLKS_12 = CLKOUT_N_12 / 2;
    localparam int FAST_CLKS_6 = CLKOUT_N_6 / 2;

    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [4:0] LOW5_MAX = 5'h1f;
    localparam logic [ADDR_W-1:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_8BIT_RELOAD, MODE_SPLIT} tcc_mode_e;

    // one count step: next count and overflow
    typedef struct packed {
        logic ovf;
        logic [15:0] cnt;
    } tcc_step_s;

    // input pins after synchronisation: level and falling edge
    typedef struct packed {
        logic p10;
        logic trig;
        logic t1_cnt;
        logic t0_cnt;
        logic irq1;
        logic irq0;
    } tcc_pins_s;

    typedef struct packed {
        tcc_pins_s s1;
        tcc_pins_s s2;
        tcc_pins_s prev;
        tcc_pins_s fall;
    } tcc_sync_s;

    typedef struct packed {
        logic [3:0] cnt;
        logic [1:0] fast_cnt;
        logic mc_tick;
        logic fast_tick;
    } tcc_presc_s;

    typedef struct packed {
        logic [7:0] t01_mode;
        logic [7:0] t01_ctrl;
        logic [7:0] t2_ctrl;
        logic [7:0] t2_mode;
        logic [15:0] t0_cnt;
        logic [15:0] t1_cnt;
        logic [15:0] t2_cnt;
        logic [15:0] t2_reload;
        logic six_clk;
        logic t0_gate_on;
        logic t1_gate_on;
        logic clkout;
        logic clkout_oe;
        logic rx_tick;
        logic tx_tick;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tcc_state_s;

    // advance a count by one in modes 0 to 2 of the first two timers
    function automatic tcc_step_s tcc_step(input tcc_mode_e mode, input logic [15:0] cnt);
        tcc_step_s r;
        r.ovf = 1'b0;
        r.cnt = cnt;
        unique case (mode)
            MODE_13BIT:
            begin
                r.cnt[4:0] = cnt[4:0] + 5'h01;
                r.cnt[7:5] = 3'h0;
                if (cnt[4:0] == LOW5_MAX)
                begin
                    r.cnt[15:8] = cnt[15:8] + 8'h01;
                    r.ovf = (cnt[15:8] == BYTE_MAX);
                end
            end
            MODE_16BIT:
            begin
                r.cnt = cnt + 16'h0001;
                r.ovf = (cnt == CNT_MAX);
            end
            MODE_8BIT_RELOAD:
            begin
                r.ovf = (cnt[7:0] == BYTE_MAX);
                r.cnt[7:0] = r.ovf ? cnt[15:8] : cnt[7:0] + 8'h01;
            end
            MODE_SPLIT:
            begin
                r.cnt = cnt;
            end
        endcase
        return r;
    endfunction

endpackage

// ### hw/tcc_pin_sync.sv
// two-stage synchroniser and falling-edge detector for the external pins
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_sync
    import tcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire tcc_pins_s pins,
    output tcc_pins_s level,
    output tcc_pins_s fall
);

    tcc_sync_s s_r;
    tcc_sync_s s_nxt;

    // ----------------------------------------------------------------
    // next state: only the second stage feeds the edge logic
    // ----------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        if (ce)
        begin
            s_nxt.s1 = pins;
            s_nxt.s2 = s_r.s1;
            s_nxt.prev = s_r.s2;
            s_nxt.fall = s_r.prev & ~s_r.s2;
        end
    end

    // stages reset to the idle-high level and the edge flop to none, so no false edge follows release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_r <= '{s1: '1, s2: '1, prev: '1, fall: '0};
        else
            s_r <= s_nxt;
    end

    assign level = s_r.s2;
    assign fall = s_r.fall & {$bits(tcc_pins_s){ce}};

endmodule
`default_nettype wire

// ### hw/tcc_prescaler.sv
// machine-cycle and fast count-step tick generator
`timescale 1ns/1ns
`default_nettype none
module tcc_prescaler
    import tcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic six_clk,
    output logic mc_tick,
    output logic fast_tick
);

    tcc_presc_s s_r;
    tcc_presc_s s_nxt;
    logic [3:0] mc_last;
    logic [1:0] fast_last;

    // ----------------------------------------------------------------
    // free-running dividers, restarted at the terminal count
    // ----------------------------------------------------------------
    always_comb
    begin
        mc_last = six_clk ? 4'(MC_CLKS_6 - 1) : 4'(MC_CLKS_12 - 1);
        fast_last = six_clk ? 2'(FAST_CLKS_6 - 1) : 2'(FAST_CLKS_12 - 1);
        s_nxt = s_r;
        if (ce)
        begin
            s_nxt.mc_tick = (s_r.cnt >= mc_last);
            s_nxt.cnt = s_nxt.mc_tick ? 4'h0 : s_r.cnt + 4'h1;
            s_nxt.fast_tick = (s_r.fast_cnt >= fast_last);
            s_nxt.fast_cnt = s_nxt.fast_tick ? 2'h0 : s_r.fast_cnt + 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // ticks are one-cycle pulses, but fast_tick stays high every cycle in 6-clock mode; gated by ce so a frozen block sees none
    assign mc_tick = s_r.mc_tick & ce;
    assign fast_tick = s_r.fast_tick & ce;

endmodule
`default_nettype wire

// ### testbench/tcc_pin_model.sv
// partner model: external gate, count, trigger and p10 pins, idle high
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_model
(
    input wire logic pclk,
    input wire logic [5:0] req,
    output logic [5:0] pins
);
    // -------------------------------------------------
    // pin pulse shaping
    // -------------------------------------------------
    logic [5:0] s1_r = 6'h00;
    logic [5:0] s2_r = 6'h00;
    logic [5:0] s3_r = 6'h00;
    // a request gives a 3-cycle low pulse, long enough for the 2-flop sync
    always @(posedge pclk)
    begin
        s1_r <= req;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end
    assign pins = ~(s1_r | s2_r | s3_r);
endmodule
`default_nettype wire

// ### testbench/tcc_timers_asserts.sv
// checker of the timer block port behaviour
`timescale 1ns/1ns
`default_nettype none
module tcc_timers_asserts
    import tcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic p10_pin_o,
    input wire logic p10_pin_oe,
    input wire logic t0_ovf_flag,
    input wire logic t2_ovf_flag
);
    // -------------------------------------------------
    // properties
    // -------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_wait;
        psel && $rose(penable) |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("access not answered");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    property p_err_map;
        pslverr |-> pready && (paddr[1:0] != 2'h0 || paddr > OFS_CLK_CFG);
    endproperty
    a_err_map: assert property (p_err_map) else $error("error on mapped address");
    property p_wr_zero;
        pready && pwrite |-> prdata == 32'h0;
    endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("read data on write");
    property p_flag_sticky;
        $fell(t0_ovf_flag) |-> $past(pready && pwrite);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
    property p_out_low;
        !p10_pin_oe |-> !p10_pin_o;
    endproperty
    a_out_low: assert property (p_out_low) else $error("pin high undriven");
    // half period of 2*(65536-fffc) pclk in 12-clock mode
    property p_clk_half;
        p10_pin_oe && $changed(p10_pin_o) |=> (!p10_pin_oe || $stable(p10_pin_o)) [*7]
            ##1 (!p10_pin_oe || $changed(p10_pin_o));
    endproperty
    a_clk_half: assert property (p_clk_half) else $error("clock half period");
    property p_no_ovf;
        $rose(t2_ovf_flag) |-> !$past(p10_pin_oe);
    endproperty
    a_no_ovf: assert property (p_no_ovf) else $error("overflow in clock-out");
    c_clk: cover property (p10_pin_oe && $rose(p10_pin_o));
    c_err: cover property (pslverr);
    c_ovf: cover property ($rose(t0_ovf_flag));
endmodule
bind tcc_timers tcc_timers_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .p10_pin_o(p10_pin_o),
    .p10_pin_oe(p10_pin_oe), .t0_ovf_flag(t0_ovf_flag), .t2_ovf_flag(t2_ovf_flag));
`default_nettype wire

// ### testbench/test_tcc_timers.sv
// testbench of the timer block over apb and pins
`timescale 1ns/1ns
`default_nettype none
module test_tcc_timers
    import tcc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = RST_BYTE;
    logic [31:0] pwdata = 32'h0;
    logic [5:0] req = 6'h00;
    wire logic [5:0] pins;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, p10_o, p10_oe, f0, f1, f2, fx, rxt, txt;
    logic [31:0] rdat;
    logic rerr, saw_tx;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    tcc_pin_model i_pins (.pclk(pclk), .req(req), .pins(pins));
    tcc_timers i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_irq0_pin(pins[0]), .ext_irq1_pin(pins[1]), .t0_count_pin(pins[2]), .t1_count_pin(pins[3]),
        .timer2_trigger_pin(pins[4]), .p10_pin_i(pins[5]), .p10_pin_o(p10_o), .p10_pin_oe(p10_oe),
        .t0_ovf_flag(f0), .t1_ovf_flag(f1), .t2_ovf_flag(f2), .t2_ext_flag(fx), .baud_rx_tick(rxt),
        .baud_tx_tick(txt));
    // -------------------------------------------------
    // clock, timeout and shared tasks
    // -------------------------------------------------
    always #4 pclk = ~pclk;
    // a hang ends the run through the same verdict
    always @(posedge pclk)
    begin
        cyc++;
        if (txt === 1'b1 && rxt === 1'b1) saw_tx = 1'b1;
        if (cyc == 20000)
        begin
            err_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // one apb transfer; waits for pready, idles a cycle after release
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench timeout ends this wait
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic pulse(input int i);
        req[i] <= 1'b1;
        @(posedge pclk);
        req[i] <= 1'b0;
        repeat (7) @(posedge pclk);
    endtask
    // -------------------------------------------------
    // tests
    // -------------------------------------------------
    initial
    begin
        saw_tx = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, OFS_T2_RELOAD, 0);
        chk(rdat, 32'h0, "reload reset");
        apb(0, 8'h40, 0);
        chk({rdat[30:0], rerr}, 32'h1, "unmapped read");
        $display("test regs done");
        apb(1, OFS_T01_MODE, 32'h01);
        apb(1, OFS_T0_CNT, 32'hfffe);
        apb(1, OFS_T01_CTRL, 32'h10);
        repeat (40) @(posedge pclk);
        chk(f0, 1, "t0 overflow");
        apb(1, OFS_T01_CTRL, 32'h00);
        apb(0, OFS_T0_CNT, 0);
        n = rdat;
        repeat (30) @(posedge pclk);
        apb(0, OFS_T0_CNT, 0);
        chk(rdat, n, "t0 stopped");
        apb(1, OFS_T01_MODE, 32'h0d);
        apb(1, OFS_T0_CNT, 32'h0);
        apb(1, OFS_T01_CTRL, 32'h10);
        pulse(2);
        pulse(2);
        pulse(0);
        pulse(2);
        apb(0, OFS_T0_CNT, 0);
        chk(rdat, 32'h1, "gated counter");
        apb(1, OFS_T01_MODE, 32'h10);
        apb(1, OFS_T1_CNT, 32'hfffe);
        apb(1, OFS_T01_CTRL, 32'h40);
        repeat (40) @(posedge pclk);
        chk(f1, 1, "t1 overflow");
        apb(1, OFS_T2_RELOAD, 32'h1234);
        apb(1, OFS_T2_CTRL, 32'h0c);
        pulse(4);
        apb(0, OFS_T2_CNT, 0);
        chk({rdat[15:8], 7'h0, fx}, 16'h1201, "trigger reload");
        $display("test timers done");
        apb(1, OFS_T2_RELOAD, 32'hfffc);
        apb(1, OFS_T2_CNT, 32'hfffc);
        apb(1, OFS_T2_MODE, 32'h02);
        apb(1, OFS_T2_CTRL, 32'h34);
        n = 0;
        do @(posedge pclk); while (p10_o !== 1'b1 && ++n < 200);
        n = 0;
        // one edge counted per pass, so a full period of 16 clocks reads 16
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (p10_o === 1'b1 && n < 200);
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (p10_o !== 1'b1 && n < 200);
        chk(n, 16, "clock-out period");
        chk({p10_oe, f2, saw_tx}, 3'b101, "clock-out flags");
        apb(1, OFS_T2_MODE, 32'h00);
        apb(1, OFS_T2_CTRL, 32'h00);
        apb(1, OFS_T2_CNT, 32'hffff);
        apb(1, OFS_T2_CTRL, 32'h06);
        pulse(5);
        pulse(5);
        apb(0, OFS_T2_CNT, 0);
        chk({rdat[15:0], 3'h0, f2}, 20'hfffd1, "p10 count input");
        $display("test clock-out done");
        finish_test();
    end
endmodule
`default_nettype wire
